// file: acsp_pkg.sv
// Shared constants and types for the converter control and serial port
package acsp_pkg;
	localparam int WORD_W       = 16;
	localparam int CNT_W        = 16;
	localparam int DIV_W        = 8;
	localparam int ADR_W        = 4;
	localparam int CLK_NS       = 25;
	localparam int START_SAMPLE_N_TIME_NS = 10000;
	localparam int RST_TIME_NS  = 1000;
	localparam int MCLK_IDLE_NS = 1000;
	// Least times round up, the idle limit rounds down
	localparam int START_SAMPLE_N_CYC      = (START_SAMPLE_N_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CYC       = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int MCLK_IDLE_CYC = MCLK_IDLE_NS / CLK_NS;
	localparam logic [ADR_W-1:0] STATUS_ADR = 4'h0;
	localparam logic [ADR_W-1:0] RESULT_ADR = 4'h4;
	localparam logic [ADR_W-1:0] CTRL_ADR   = 4'h8;
	localparam logic [DIV_W-1:0] CTRL_RST   = 8'h04;
	localparam int SB_RDY   = 0;
	localparam int SB_BUSY  = 1;
	localparam int SB_ROLE  = 2;
	localparam int SB_SPAN  = 3;
	localparam int SB_DITH  = 4;
	localparam int SB_EXT   = 5;
	localparam int SB_STOP  = 6;
	localparam logic [WORD_W-1:0] MIDSCALE   = 16'h8000;
	localparam logic [WORD_W-1:0] LFSR_SEED  = 16'hACE1;
	localparam logic [WORD_W-1:0] LFSR_TAPS  = 16'hB400;
	localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;

	typedef struct packed {
		logic mclk;
		logic csN;
		logic startN;
		logic sclk;
		logic role;
		logic span;
		logic dither;
	} acsp_pins_t;

	typedef enum logic [1:0] {CV_RESET, CV_IDLE, CV_START_SAMPLE_N} acsp_start_sample_n_t;
endpackage : acsp_pkg

// file: acsp_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module acsp_sync #(
	parameter int           W    = 1,
	// Reset value of each stage, the idle level of its pin
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					meta_q[i] <= INIT[i];
					dout[i]   <= INIT[i];
				end else if (ce) begin
					meta_q[i] <= din[i];
					dout[i]   <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule : acsp_sync

// file: acsp_top.sv
// Converter control, result coding and serial output port
//
// What this block does
// - Serial data output floats while port select is high.
// - Role strap high: device is master, drives shift clock and data.
// - Role strap low: device is slave, host supplies the shift clock.
// - Span select high: bipolar span, two's complement result coding.
// - Span select low: unipolar span zero to plus, straight binary coding.
// - Randomize select high dithers words; low leaves plain quantized words.
// - Reset low holds logic; after release ready falls once reset completes.
// - Start low begins conversion; result loads shift register, ready falls.
// - Start still low when ready falls starts the next conversion at once.
// - Master clock pin low selects internal oscillator as clock source.
// - Master clock pin held high stops conversion timing and the master shift clock.
// - A toggling master clock pin replaces the internal oscillator.
// - Word goes out MSB first, next bit on each shift clock rise.
// - Self-clocked shift clock is derived from the active master source.
// - Self-clocked shift clock output floats while port select is high.
// - Ready returns high after all result bits are shifted out.
`timescale 1ns/1ps
module acsp_top
	import acsp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	// Strap and control pins
	input  wire logic              portRoleSel,
	input  wire logic              spanPolaritySel,
	input  wire logic              ditherSel,
	input  wire logic              startSampleN,
	input  wire logic              mclkPin,
	// Filter result, same clock domain
	input  wire logic [WORD_W-1:0] sampleIn,
	// Serial port pins
	input  wire logic              csN,
	input  wire logic              sclkIn,
	output logic                   sclkOut,
	output logic                   sclkOe,
	output logic                   serialOut,
	output logic                   serialOe,
	output logic                   rdyN,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o
);
	////////////////////////////////////////////////////////////////////////
	acsp_pins_t              pinRaw;
	acsp_pins_t              pinS;
	acsp_start_sample_n_t              convSt_q;
	logic [CNT_W-1:0]        convCnt_q;
	logic [CNT_W-1:0]        idleCnt_q;
	logic                    extClk_q;
	logic                    mclkPrev_q;
	logic                    sclkPrev_q;
	logic                    sclkOut_q;
	logic                    sclkOe_q;
	logic                    serialOe_q;
	logic                    rdyN_q;
	logic [WORD_W-1:0]       shift_q;
	logic [4:0]              bitCnt_q;
	logic [DIV_W-1:0]        divCnt_q;
	logic [DIV_W-1:0]        ctrl_q;
	logic [WORD_W-1:0]       result_q;
	logic [WORD_W-1:0]       lfsr_q;
	logic                    wbAck_q;
	logic [31:0]             wbDat_q;
	logic                    clkStop;
	logic                    tick;
	logic                    loadWord;
	logic                    sscRise;
	logic                    secRise;
	logic                    shiftEdge;
	logic                    sscRun;
	logic [WORD_W-1:0]       codedWord;

	assign pinRaw = '{mclk: mclkPin, csN: csN, startN: startSampleN, sclk: sclkIn,
		role: portRoleSel, span: spanPolaritySel, dither: ditherSel};

	// Synchroniser starts at each pin's idle level, so no false select or start follows reset
	localparam acsp_pins_t PIN_IDLE = '{mclk: 1'b0, csN: 1'b1, startN: 1'b1, sclk: 1'b0,
		role: 1'b0, span: 1'b0, dither: 1'b0};

	acsp_sync #(.W($bits(acsp_pins_t)), .INIT(PIN_IDLE)) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.ce   (ce),
		.din  (pinRaw),
		.dout (pinS)
	);

	////////////////////////////////////////////////////////////////////////
	// Result coding from the offset-binary filter word
	function automatic logic [WORD_W-1:0] code_word(input logic [WORD_W-1:0] raw,
		input logic bipolar, input logic dith, input logic rnd);
		logic [WORD_W-1:0] w;
		if (bipolar) begin
			w = raw ^ MIDSCALE;
		end else if (raw < MIDSCALE) begin
			w = WORD_ZERO;
		end else begin
			w = WORD_W'((raw - MIDSCALE) << 1);
		end
		if (dith) begin
			w[0] = w[0] ^ rnd;
		end
		return w;
	endfunction : code_word

	assign codedWord = code_word(sampleIn, pinS.span, pinS.dither, lfsr_q[0]);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lfsr_q <= LFSR_SEED;
		end else if (ce) begin
			lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ LFSR_TAPS) : (lfsr_q >> 1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master clock source: static low, toggling, or static high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mclkPrev_q <= 1'b0;
			extClk_q   <= 1'b0;
			idleCnt_q  <= '0;
		end else if (ce) begin
			mclkPrev_q <= pinS.mclk;
			if (pinS.mclk != mclkPrev_q) begin
				extClk_q  <= 1'b1;
				idleCnt_q <= '0;
			end else if (idleCnt_q == CNT_W'(MCLK_IDLE_CYC)) begin
				extClk_q <= 1'b0;
			end else begin
				idleCnt_q <= idleCnt_q + 1'b1;
			end
		end
	end

	// A slow external clock counts as static once it idles past the limit
	assign clkStop = !extClk_q && pinS.mclk;
	always_comb begin
		if (extClk_q) begin
			tick = pinS.mclk && !mclkPrev_q;
		end else begin
			tick = !pinS.mclk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset sequence and conversion timing
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			convSt_q  <= CV_RESET;
			convCnt_q <= '0;
		end else if (ce) begin
			unique case (convSt_q)
				CV_RESET: begin
					if (convCnt_q == CNT_W'(RST_CYC - 1)) begin
						convSt_q  <= CV_IDLE;
						convCnt_q <= '0;
					end else begin
						convCnt_q <= convCnt_q + 1'b1;
					end
				end
				CV_IDLE: begin
					if (!pinS.startN && tick) begin
						convSt_q  <= CV_START_SAMPLE_N;
						convCnt_q <= '0;
					end
				end
				CV_START_SAMPLE_N: begin
					if (tick) begin
						if (convCnt_q == CNT_W'(START_SAMPLE_N_CYC - 1)) begin
							convCnt_q <= '0;
							convSt_q  <= pinS.startN ? CV_IDLE : CV_START_SAMPLE_N;
						end else begin
							convCnt_q <= convCnt_q + 1'b1;
						end
					end
				end
			endcase
		end
	end

	assign loadWord = (convSt_q == CV_RESET && convCnt_q == CNT_W'(RST_CYC - 1))
		|| (convSt_q == CV_START_SAMPLE_N && tick && convCnt_q == CNT_W'(START_SAMPLE_N_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// Shift clock generation in master mode, from the active source
	// Clocking waits for both enables, so the first bit stands on the line before the first rise
	assign sscRun  = pinS.role && !pinS.csN && sclkOe_q && serialOe_q && !rdyN_q;
	assign sscRise = sscRun && tick && (divCnt_q == ctrl_q) && !sclkOut_q;
	assign secRise = !pinS.role && pinS.sclk && !sclkPrev_q;
	assign shiftEdge = !pinS.csN && (pinS.role ? sscRise : secRise);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			divCnt_q   <= '0;
			sclkOut_q  <= 1'b0;
			sclkPrev_q <= 1'b0;
		end else if (ce) begin
			sclkPrev_q <= pinS.sclk;
			if (!sscRun || loadWord) begin
				divCnt_q  <= '0;
				sclkOut_q <= 1'b0;
			end else if (tick) begin
				if (divCnt_q == ctrl_q) begin
					divCnt_q  <= '0;
					sclkOut_q <= !sclkOut_q;
				end else begin
					divCnt_q <= divCnt_q + 1'b1;
				end
			end
		end
	end

	// Enables are registered, so a select change shows one cycle later
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclkOe_q   <= 1'b0;
			serialOe_q <= 1'b0;
		end else if (ce) begin
			sclkOe_q   <= pinS.role && !pinS.csN;
			serialOe_q <= !pinS.csN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output shift register and ready flag
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shift_q  <= '0;
			bitCnt_q <= '0;
			rdyN_q   <= 1'b1;
			result_q <= '0;
		end else if (ce) begin
			if (loadWord) begin
				shift_q  <= codedWord;
				result_q <= codedWord;
				bitCnt_q <= '0;
				rdyN_q   <= 1'b0;
			end else if (shiftEdge && !rdyN_q) begin
				shift_q  <= shift_q << 1;
				bitCnt_q <= bitCnt_q + 1'b1;
				if (bitCnt_q == 5'(WORD_W - 1)) begin
					rdyN_q <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave, one wait state, unmapped reads return zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wbAck_q <= 1'b0;
			wbDat_q <= '0;
			ctrl_q  <= CTRL_RST;
		end else if (ce) begin
			wbAck_q <= wb_cyc_i && wb_stb_i && !wbAck_q;
			wbDat_q <= '0;
			if (wb_cyc_i && wb_stb_i && !wbAck_q) begin
				if (wb_we_i && wb_adr_i == CTRL_ADR && wb_sel_i[0]) begin
					ctrl_q <= wb_dat_i[DIV_W-1:0];
				end
				unique case (wb_adr_i)
					STATUS_ADR: begin
						wbDat_q[SB_RDY]  <= rdyN_q;
						wbDat_q[SB_BUSY] <= convSt_q == CV_START_SAMPLE_N;
						wbDat_q[SB_ROLE] <= pinS.role;
						wbDat_q[SB_SPAN] <= pinS.span;
						wbDat_q[SB_DITH] <= pinS.dither;
						wbDat_q[SB_EXT]  <= extClk_q;
						wbDat_q[SB_STOP] <= clkStop;
					end
					RESULT_ADR: wbDat_q[WORD_W-1:0] <= result_q;
					CTRL_ADR: wbDat_q[DIV_W-1:0] <= ctrl_q;
					default: wbDat_q <= '0;
				endcase
			end
		end
	end

	assign sclkOut   = sclkOut_q;
	assign sclkOe    = sclkOe_q;
	assign serialOut = shift_q[WORD_W-1];
	assign serialOe  = serialOe_q;
	assign rdyN      = rdyN_q;
	assign wb_dat_o  = wbDat_q;
	assign wb_ack_o  = wbAck_q;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_sdo_float: assert property ((ce && pinS.csN) |=> !serialOe_q)
		else $error("serial output driven while deselected");
	a_sclk_float: assert property ((ce && (pinS.csN || !pinS.role)) |=> !sclkOe_q)
		else $error("shift clock driven while deselected or slave");
	a_load_ready: assert property ((ce && loadWord) |=> (!rdyN_q && shift_q == $past(codedWord)))
		else $error("ready or word wrong after load");
	a_ready_release: assert property ((ce && !loadWord && !rdyN_q && shiftEdge
		&& bitCnt_q == 5'(WORD_W - 1)) |=> rdyN_q)
		else $error("ready not released after last bit");
	a_msb_shift: assert property ((ce && !loadWord && !rdyN_q && shiftEdge)
		|=> shift_q[WORD_W-1] == $past(shift_q[WORD_W-2]))
		else $error("shift did not advance one bit");
	a_clock_stop: assert property ((ce && clkStop) |=> $stable(convCnt_q)
		|| convSt_q == CV_RESET || $past(convSt_q) == CV_RESET)
		else $error("conversion advanced with clocks stopped");
	a_back_to_back: assert property ((ce && loadWord && convSt_q == CV_START_SAMPLE_N
		&& !pinS.startN) |=> convSt_q == CV_START_SAMPLE_N && convCnt_q == '0)
		else $error("no back to back conversion");
	a_reset_ready: assert property ((convSt_q == CV_RESET && ce) [*8] |-> rdyN_q)
		else $error("ready fell during reset sequence");
	a_internal_tick: assert property ((ce && !extClk_q && !pinS.mclk
		&& convSt_q == CV_START_SAMPLE_N && convCnt_q != CNT_W'(START_SAMPLE_N_CYC - 1))
		|=> convCnt_q == $past(convCnt_q) + 1'b1)
		else $error("internal oscillator not ticking");
	a_ssc_rate: assert property ((ce && sscRise && !loadWord)
		|=> (sclkOut_q && divCnt_q == '0))
		else $error("master shift clock not from source");
	a_wb_ack: assert property ((ce && wbAck_q) |=> !wbAck_q)
		else $error("ack held two cycles");

	c_start_sample_n_done: cover property (ce && loadWord && convSt_q == CV_START_SAMPLE_N);
	c_word_out: cover property (ce && !rdyN_q ##1 rdyN_q);
	c_ext_clock: cover property (extClk_q && loadWord);
	c_master_mode: cover property (sclkOe_q && sscRise);
	c_slave_shift: cover property (ce && secRise && !rdyN_q);
endmodule : acsp_top

// file: acsp_host_model.sv
// Host side model that reads result words over the serial port in either role
`timescale 1ns/1ps
module acsp_host_model
	import acsp_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Serial port from the block
	input  wire logic serialOut,
	input  wire logic serialOe,
	input  wire logic sclkOut,
	input  wire logic sclkOe,
	input  wire logic rdyN,
	// Host driven pins
	output logic      csN,
	output logic      sclkIn
);
	logic sdoLine, lastSdo, prevSclk, heldBit;
	logic bitQ[$];
	// A released line shows the inverse of its last level, so a stale bit never passes
	assign sdoLine = serialOe ? serialOut : ~lastSdo;
	initial begin
		csN = 1'b1;
		sclkIn = 1'b0;
		lastSdo = 1'b0;
	end
	always @(posedge clk) begin
		if (serialOe) lastSdo <= serialOut;
		prevSclk <= sclkOut & sclkOe;
		if (!sclkOut) heldBit <= sdoLine;
		if (sclkOe && sclkOut && !prevSclk) bitQ.push_back(heldBit);
	end
	////////////////////////////////////////////////////////////////////////////
	// Slave read: select, wait for ready, then 16 host clock periods of 200 ns
	task automatic read_slave(output logic [WORD_W-1:0] w, output bit ok);
		int n = 0;
		w = '0;
		csN <= 1'b0;
		while (rdyN !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		ok = (n < 3000);
		repeat (4) @(posedge clk);
		for (int i = 0; i < WORD_W; i++) begin
			w = {w[WORD_W-2:0], sdoLine};
			sclkIn <= 1'b1;
			repeat (4) @(posedge clk);
			sclkIn <= 1'b0;
			repeat (4) @(posedge clk);
		end
		csN <= 1'b1;
		@(posedge clk);
	endtask : read_slave
	// Master read: select and collect the bits the block clocks out itself
	task automatic read_master(output logic [WORD_W-1:0] w, output bit ok);
		int n = 0;
		bitQ.delete();
		csN <= 1'b0;
		while (bitQ.size() < WORD_W && n < 3000) begin
			@(posedge clk);
			n++;
		end
		ok = (n < 3000);
		w = '0;
		foreach (bitQ[i]) w = {w[WORD_W-2:0], bitQ[i]};
		csN <= 1'b1;
		@(posedge clk);
	endtask : read_master
endmodule : acsp_host_model

// file: tb_acsp_top.sv
// Self-checking bench for the converter control and serial port block
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g));
module tb_acsp_top
	import acsp_pkg::*;
;
	logic              clk, nrst, ce, portRoleSel, spanPolaritySel, ditherSel;
	logic              startSampleN, mclkPin, mclkRun, mclkDiv;
	logic [WORD_W-1:0] sampleIn;
	logic              csN, sclkIn, sclkOut, sclkOe, serialOut, serialOe, rdyN;
	logic              wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0]        wb_sel_i;
	logic [ADR_W-1:0]  wb_adr_i;
	logic [31:0]       wb_dat_i, wb_dat_o;
	int                err_count, compares;
	int                expQ[$];
	acsp_top dut_u (
		.clk, .nrst, .ce, .portRoleSel, .spanPolaritySel, .ditherSel, .startSampleN,
		.mclkPin, .sampleIn, .csN, .sclkIn, .sclkOut, .sclkOe, .serialOut, .serialOe,
		.rdyN, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o
	);
	acsp_host_model host_u (
		.clk, .serialOut, .serialOe, .sclkOut, .sclkOe, .rdyN, .csN, .sclkIn
	);
	initial begin
		clk = 1'b0;
		forever #(CLK_NS / 2.0) clk = ~clk;
	end
	always @(posedge clk) begin
		if (mclkRun) begin
			mclkDiv <= ~mclkDiv;
			if (mclkDiv) mclkPin <= ~mclkPin;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	function automatic int model_word(int raw, bit bp);
		if (bp) return raw ^ 32'h8000;
		return (raw < 32'h8000) ? 32'h0 : (((raw - 32'h8000) << 1) & 32'hFFFF);
	endfunction : model_word
	task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		if (n >= 50) err_count++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk);
	endtask : wb_xfer
	task automatic wait_rdy(output int n);
		n = 0;
		while (rdyN !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_rdy
	task automatic set_sample(input int raw);
		sampleIn <= raw[WORD_W-1:0];
		expQ.push_back(model_word(raw, spanPolaritySel));
	endtask : set_sample
	task automatic convert(input int raw);
		// With an external clock, start falls together with a falling master clock edge
		while (mclkRun && !(mclkPin && mclkDiv)) @(posedge clk);
		set_sample(raw);
		startSampleN <= 1'b0;
		repeat (12) @(posedge clk);
		startSampleN <= 1'b1;
		@(posedge clk);
	endtask : convert
	// Dither only touches the LSB, so that bit is masked when dither is on
	task automatic get_word(input bit dith);
		logic [WORD_W-1:0] w;
		logic [31:0]       q;
		bit                ok;
		int                e;
		int                m;
		if (portRoleSel) host_u.read_master(w, ok);
		else host_u.read_slave(w, ok);
		e = expQ.pop_front();
		m = dith ? 32'hFFFE : 32'hFFFF;
		`CHK("word arrived", 1, ok)
		`CHK("serial word", e & m, w & m)
		wb_xfer(1'b0, RESULT_ADR, 32'h0, q);
		`CHK("result reg", e & m, q & m)
		repeat (6) @(posedge clk);
		`CHK("ready after shift", 1, rdyN)
		`CHK("data float", 0, serialOe)
		`CHK("clock float", 0, sclkOe)
	endtask : get_word
	task automatic chk_status();
		logic [31:0] q;
		wb_xfer(1'b0, STATUS_ADR, 32'h0, q);
		`CHK("role bit", portRoleSel, q[SB_ROLE])
		`CHK("span bit", spanPolaritySel, q[SB_SPAN])
		`CHK("dither bit", ditherSel, q[SB_DITH])
	endtask : chk_status
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#(CLK_NS * 60000);
		err_count++;
		close_out();
	end
	initial begin
		logic [31:0] q;
		int          n;
		int          div;
		int          raws[4];
		raws = '{32'h8000, 32'h7FFF, 32'hFFFF, 32'h0};
		void'($urandom(31));
		{nrst, portRoleSel, ditherSel, mclkPin, mclkRun, mclkDiv} = '0;
		{ce, spanPolaritySel, startSampleN} = 3'h7;
		sampleIn = 16'h8000;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hF;
		repeat (12) @(posedge clk);
		`CHK("ready in reset", 1, rdyN)
		`CHK("oe in reset", 0, serialOe | sclkOe)
		nrst <= 1'b1;
		expQ.push_back(model_word(32'h8000, 1'b1));
		wait_rdy(n);
		`CHK("reset ready time", 1, n >= RST_CYC && n <= RST_CYC + 6)
		get_word(1'b0);
		wb_xfer(1'b0, CTRL_ADR, 32'h0, q);
		`CHK("divider reset", CTRL_RST, q[7:0])
		div = $urandom_range(3);
		wb_xfer(1'b1, CTRL_ADR, div, q);
		wb_xfer(1'b0, CTRL_ADR, 32'h0, q);
		`CHK("divider", div, q[7:0])
		wb_xfer(1'b0, 4'hC, 32'h0, q);
		`CHK("unmapped read", 0, q)
		for (int c = 0; c < 4; c++) begin
			spanPolaritySel <= c[0];
			ditherSel <= c[1];
			repeat (4) @(posedge clk);
			chk_status();
			for (int k = 0; k < 5; k++) begin
				convert(k < 4 ? raws[k] : $urandom_range(16'hFFFF));
				get_word(c[1]);
			end
		end
		portRoleSel <= 1'b1;
		spanPolaritySel <= 1'b1;
		ditherSel <= 1'b0;
		repeat (4) @(posedge clk);
		chk_status();
		convert($urandom_range(16'hFFFF));
		get_word(1'b0);
		// Start held low across loads chains the conversions
		set_sample(16'h1234);
		startSampleN <= 1'b0;
		wait_rdy(n);
		wb_xfer(1'b0, STATUS_ADR, 32'h0, q);
		`CHK("busy at load", 1, q[SB_BUSY])
		get_word(1'b0);
		set_sample(16'hEDCB);
		get_word(1'b0);
		startSampleN <= 1'b1;
		set_sample(16'hEDCB);
		get_word(1'b0);
		portRoleSel <= 1'b0;
		mclkPin <= 1'b1;
		repeat (100) @(posedge clk);
		startSampleN <= 1'b0;
		repeat (600) @(posedge clk);
		`CHK("no word when stopped", 1, rdyN)
		wb_xfer(1'b0, STATUS_ADR, 32'h0, q);
		`CHK("stop flag", 1, q[SB_STOP])
		startSampleN <= 1'b1;
		mclkRun <= 1'b1;
		repeat (60) @(posedge clk);
		convert($urandom_range(16'hFFFF));
		wb_xfer(1'b0, STATUS_ADR, 32'h0, q);
		`CHK("external flag", 1, q[SB_EXT])
		get_word(1'b0);
		mclkRun <= 1'b0;
		@(posedge clk);
		mclkPin <= 1'b0;
		repeat (60) @(posedge clk);
		convert($urandom_range(16'hFFFF));
		get_word(1'b0);
		close_out();
	end
endmodule : tb_acsp_top
